//--- design/drw_decoder.sv
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
// Command decoder for level-setting register writes and readbacks
module drw_decoder (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [drw_pkg::ADDR_W-1:0] paddr,
    input wire logic [drw_pkg::DATA_W-1:0] pwdata,
    output logic [drw_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Control register write and read strobes, with channel and word
    output logic ctrl_wr_stb_q,
    output logic ctrl_rd_stb_q,
    output logic [1:0] ctrl_chan_q,
    output logic [drw_pkg::CTRL_W-1:0] ctrl_word_q,
    // Correction trigger
    output logic corr_stb_q,
    output logic [1:0] corr_chan_q,
    output logic [2:0] corr_set_q,
    output logic [2:0] corr_level_q,
    output logic [drw_pkg::WORD_W-1:0] raw_level_word_q
);
    import drw_pkg::*;

    // Storage index shared by write and read
    function automatic logic [MEM_AW-1:0] mem_index(input logic [1:0] chan, input logic [CMD_W-1:0] cmd);
        mem_index = {chan, cmd[TGT_LSB+:2], cmd[SET_LSB+:3], cmd[LEVEL_LSB+:3]};
    endfunction

    // Lowest selected channel; readback returns one word only
    function automatic logic [1:0] first_chan(input logic [3:0] mask);
        first_chan = 2'h0;
        if (mask[0]) begin
            first_chan = 2'h0;
        end else if (mask[1]) begin
            first_chan = 2'h1;
        end else if (mask[2]) begin
            first_chan = 2'h2;
        end else if (mask[3]) begin
            first_chan = 2'h3;
        end
    endfunction

    // Registers and state
    drw_state_t state_q; // Decoder state
    logic [CMD_W-1:0] cmd_q; // Last whole command word
    logic [1:0] chan_q; // Channel being walked
    logic [WORD_W-1:0] rd_word_q; // Readback result
    logic rd_valid_q; // Readback result present
    logic [DATA_W-1:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    // Decoded fields of the held command
    logic [3:0] chan_mask; // One select bit per channel
    logic [1:0] target; // Register type
    logic [WORD_W-1:0] data_field; // Low sixteen bits
    logic chan_hit; // Walked channel is selected
    logic busy;
    logic access; // Access phase awaiting answer
    logic cmd_take; // Whole command word accepted
    logic mem_we;
    logic mem_re;
    logic [WORD_W-1:0] mem_wdata;
    logic [WORD_W-1:0] mem_rdata;

    assign chan_mask = cmd_q[CHAN_LSB+:4];
    assign target = cmd_q[TGT_LSB+:2];
    assign data_field = cmd_q[WORD_W-1:0];
    assign chan_hit = chan_mask[chan_q];
    assign busy = (state_q != DRW_IDLE);
    assign access = psel && penable && !pready_q;
    // Command acts at the completing edge, once the whole word is in
    // Busy is already known low here, since pready was held off while busy
    assign cmd_take = psel && penable && pready_q && pwrite && (paddr == OFF_CMD) && !busy;

    // Gain keeps fifteen bits; bit 0 of data is dropped
    always_comb begin
        if (target == TGT_GAIN) begin
            mem_wdata = {data_field[WORD_W-1:1], 1'b0};
        end else begin
            mem_wdata = data_field;
        end
    end

    // Store only non-control targets, one selected channel per cycle
    assign mem_we = (state_q == DRW_WRITE) && chan_hit && (target != TGT_CTRL);
    assign mem_re = (state_q == DRW_READ) && (target != TGT_CTRL);

    // Level storage
    drw_level_mem u_mem (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(mem_we),
        .wr_addr(mem_index(chan_q, cmd_q)),
        .wr_data(mem_wdata),
        .rd_en(mem_re),
        .rd_addr(mem_index(first_chan(chan_mask), cmd_q)),
        .rd_data_q(mem_rdata)
    );

    // APB answer; a command write waits while the previous one runs
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= ZERO_WORD;
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            if (access && !(pwrite && (paddr == OFF_CMD) && busy)) begin
                pready_q <= 1'b1;
                prdata_q <= ZERO_WORD;
                case (paddr)
                    OFF_CMD: begin
                        if (!pwrite) begin
                            prdata_q <= {3'h0, cmd_q};
                        end
                    end
                    OFF_STATUS: begin
                        if (!pwrite) begin
                            prdata_q[ST_BUSY_BIT] <= busy;
                            prdata_q[ST_VALID_BIT] <= rd_valid_q;
                        end
                    end
                    OFF_RDATA: begin
                        if (!pwrite) begin
                            prdata_q <= {15'h0000, rd_valid_q, rd_word_q};
                        end
                    end
                    // Unmapped address answers with an error
                    default: begin
                        pslverr_q <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Command capture
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmd_q <= CMD_RESET;
        end else if (cmd_take) begin
            cmd_q <= pwdata[CMD_W-1:0];
        end
    end

    // Sequencer: writes walk all four channels, reads take one
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= DRW_IDLE;
            chan_q <= 2'h0;
        end else begin
            case (state_q)
                DRW_IDLE: begin
                    chan_q <= 2'h0;
                    if (cmd_take) begin
                        if (pwdata[BIT_RDWR]) begin
                            state_q <= DRW_READ;
                        end else begin
                            state_q <= DRW_WRITE;
                        end
                    end
                end
                DRW_WRITE: begin
                    chan_q <= chan_q + 2'h1;
                    if (chan_q == 2'h3) begin
                        state_q <= DRW_IDLE;
                    end
                end
                DRW_READ: begin
                    // Control readback has no local storage to wait on
                    if (target == TGT_CTRL) begin
                        state_q <= DRW_IDLE;
                    end else begin
                        state_q <= DRW_RWAIT;
                    end
                end
                DRW_RWAIT: begin
                    state_q <= DRW_IDLE;
                end
                default: begin
                    state_q <= DRW_IDLE;
                end
            endcase
        end
    end

    // Readback result; valid flag cleared when a new readback starts
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_word_q <= WORD_W'(0);
            rd_valid_q <= 1'b0;
        end else if (cmd_take && pwdata[BIT_RDWR]) begin
            rd_valid_q <= 1'b0;
        end else if (state_q == DRW_READ && target == TGT_CTRL) begin
            rd_word_q <= WORD_W'(0);
            rd_valid_q <= 1'b1;
        end else if (state_q == DRW_RWAIT) begin
            rd_word_q <= mem_rdata;
            rd_valid_q <= 1'b1;
        end
    end

    // Control register strobes toward the channel control logic
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_wr_stb_q <= 1'b0;
            ctrl_rd_stb_q <= 1'b0;
            ctrl_chan_q <= 2'h0;
            ctrl_word_q <= CTRL_W'(0);
        end else begin
            ctrl_wr_stb_q <= 1'b0;
            ctrl_rd_stb_q <= 1'b0;
            if (state_q == DRW_WRITE && chan_hit && target == TGT_CTRL) begin
                ctrl_wr_stb_q <= 1'b1;
                ctrl_chan_q <= chan_q;
                ctrl_word_q <= cmd_q[CTRL_W-1:0];
            end else if (state_q == DRW_READ && target == TGT_CTRL) begin
                ctrl_rd_stb_q <= 1'b1;
                ctrl_chan_q <= first_chan(chan_mask);
                ctrl_word_q <= cmd_q[CTRL_W-1:0];
            end
        end
    end

    // Correction trigger; gain or offset updates alone stay silent
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            corr_stb_q <= 1'b0;
            corr_chan_q <= 2'h0;
            corr_set_q <= 3'h0;
            corr_level_q <= 3'h0;
            raw_level_word_q <= WORD_W'(0);
        end else begin
            corr_stb_q <= 1'b0;
            if (state_q == DRW_WRITE && chan_hit && target == TGT_INPUT) begin
                corr_stb_q <= 1'b1;
                corr_chan_q <= chan_q;
                corr_set_q <= cmd_q[SET_LSB+:3];
                corr_level_q <= cmd_q[LEVEL_LSB+:3];
                raw_level_word_q <= data_field;
            end
        end
    end

    // Bus outputs straight from flops
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
endmodule
`default_nettype wire

//--- inc/drw_pkg.sv
`default_nettype none
package drw_pkg;
    // Bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    // Register byte offsets
    localparam logic [11:0] OFF_CMD = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam logic [11:0] OFF_RDATA = 12'h008;
    // Command word layout
    localparam int CMD_W = 29;
    localparam int BIT_RDWR = 28;
    localparam int CHAN_LSB = 24;
    localparam int TGT_LSB = 22;
    localparam int SET_LSB = 19;
    localparam int LEVEL_LSB = 16;
    localparam int CTRL_W = 22;
    localparam int WORD_W = 16;
    // Target field codes
    localparam logic [1:0] TGT_CTRL = 2'h0;
    localparam logic [1:0] TGT_GAIN = 2'h1;
    localparam logic [1:0] TGT_OFFSET = 2'h2;
    localparam logic [1:0] TGT_INPUT = 2'h3;
    // Status field positions
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_VALID_BIT = 1;
    localparam int RD_VALID_BIT = 16;
    // Storage geometry: channel, target, set, level
    localparam int MEM_AW = 10;
    localparam int MEM_DEPTH = 1024;
    // Reset values
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [28:0] CMD_RESET = 29'h0000_0000;
    // Decoder states
    typedef enum logic [1:0] {
        DRW_IDLE = 2'b00,
        DRW_WRITE = 2'b01,
        DRW_READ = 2'b10,
        DRW_RWAIT = 2'b11
    } drw_state_t;
endpackage
`default_nettype wire

//--- design/drw_level_mem.sv
`timescale 1ns/100ps
`default_nettype none
// Level storage, one word per channel, target, set and level
module drw_level_mem (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Write port
    input wire logic wr_en,
    input wire logic [drw_pkg::MEM_AW-1:0] wr_addr,
    input wire logic [drw_pkg::WORD_W-1:0] wr_data,
    // Read port
    input wire logic rd_en,
    input wire logic [drw_pkg::MEM_AW-1:0] rd_addr,
    output logic [drw_pkg::WORD_W-1:0] rd_data_q
);
    import drw_pkg::*;

    // Plain array; no reset so it maps onto block memory
    logic [WORD_W-1:0] mem [0:MEM_DEPTH-1];

    // Write side
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Registered read side
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_data_q <= WORD_W'(0);
        end else if (rd_en) begin
            rd_data_q <= mem[rd_addr];
        end
    end
endmodule
`default_nettype wire

//--- tb/drw_decoder_sva.sv
`timescale 1ns/100ps
`default_nettype none
// Watches command decode at the top ports
module drw_decoder_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // APB side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [drw_pkg::ADDR_W-1:0] paddr,
    input wire logic [drw_pkg::DATA_W-1:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Decoded outputs
    input wire logic ctrl_wr_stb_q,
    input wire logic ctrl_rd_stb_q,
    input wire logic [1:0] ctrl_chan_q,
    input wire logic [drw_pkg::CTRL_W-1:0] ctrl_word_q,
    input wire logic corr_stb_q,
    input wire logic [1:0] corr_chan_q,
    input wire logic [2:0] corr_set_q,
    input wire logic [2:0] corr_level_q,
    input wire logic [drw_pkg::WORD_W-1:0] raw_level_word_q
);
    import drw_pkg::*;
    logic [31:0] cmd_q; // Last accepted command word
    // Taken at the completing edge, since strobes only follow it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmd_q <= ZERO_WORD;
        end else if (psel && penable && pready && pwrite && paddr == OFF_CMD) begin
            cmd_q <= pwdata;
        end
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // Access phase still waiting for an answer
    sequence s_waiting;
        psel && penable && !pready;
    endsequence
    // Whole input write with channel 0 selected completes
    sequence s_in_write;
        psel && penable && pready && pwrite && paddr == OFF_CMD && !pwdata[28] && pwdata[23:22] == TGT_INPUT && pwdata[24];
    endsequence
    a_answer_bound: assert property (s_waiting |-> ##[1:8] pready)
        else $error("access phase left without answer");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_err_unmapped: assert property (psel && pready && paddr > OFF_RDATA |-> pslverr)
        else $error("unmapped address without error");
    a_corr_cause: assert property (corr_stb_q |-> !cmd_q[28] && cmd_q[23:22] == TGT_INPUT)
        else $error("correction without input write");
    a_corr_fields: assert property (corr_stb_q |-> {corr_set_q, corr_level_q, raw_level_word_q} == cmd_q[21:0])
        else $error("correction fields differ from command");
    a_corr_chan: assert property (corr_stb_q |-> cmd_q[CHAN_LSB + corr_chan_q])
        else $error("correction on unselected channel");
    a_in_strobe: assert property (s_in_write |-> ##[1:2] corr_stb_q && corr_chan_q == 2'h0)
        else $error("input write gave no correction");
    a_ctrl_write: assert property (ctrl_wr_stb_q |-> cmd_q[23:22] == TGT_CTRL && !cmd_q[28]
        && cmd_q[CHAN_LSB + ctrl_chan_q] && ctrl_word_q == cmd_q[21:0])
        else $error("control write strobe mismatch");
    a_ctrl_read: assert property (ctrl_rd_stb_q |-> cmd_q[28] && cmd_q[23:22] == TGT_CTRL && !ctrl_wr_stb_q)
        else $error("control readback strobe mismatch");
endmodule
bind drw_decoder drw_decoder_sva chk_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .ctrl_wr_stb_q(ctrl_wr_stb_q), .ctrl_rd_stb_q(ctrl_rd_stb_q), .ctrl_chan_q(ctrl_chan_q),
    .ctrl_word_q(ctrl_word_q), .corr_stb_q(corr_stb_q), .corr_chan_q(corr_chan_q),
    .corr_set_q(corr_set_q), .corr_level_q(corr_level_q), .raw_level_word_q(raw_level_word_q));
`default_nettype wire

//--- tb/drw_host.sv
`timescale 1ns/100ps
`default_nettype none
// Host controller model: APB master writing command words
module drw_host (
    // Clock
    input wire logic clk,
    // APB master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [drw_pkg::ADDR_W-1:0] paddr,
    output logic [drw_pkg::DATA_W-1:0] pwdata,
    input wire logic [drw_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    int lost = 0; // Transfers that never got pready
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end
    // One transfer; an idle cycle follows so psel never toggles twice in a step
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        if (n >= 20) lost++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

//--- tb/dac_register_write_decoder_test.sv
`timescale 1ns/100ps
`default_nettype none
// Command decoder bench
module dac_register_write_decoder_test;
    import drw_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, ctrl_wr_stb_q, ctrl_rd_stb_q, corr_stb_q;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] ctrl_chan_q, corr_chan_q;
    logic [21:0] ctrl_word_q;
    logic [2:0] corr_set_q, corr_level_q;
    logic [15:0] raw_level_word_q;
    logic err;
    int failures = 0, checked = 0, n_corr = 0, n_wr = 0, n_rd = 0;
    always #5 clk = ~clk;
    drw_host host_u (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    drw_decoder dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ctrl_wr_stb_q(ctrl_wr_stb_q), .ctrl_rd_stb_q(ctrl_rd_stb_q), .ctrl_chan_q(ctrl_chan_q),
        .ctrl_word_q(ctrl_word_q), .corr_stb_q(corr_stb_q), .corr_chan_q(corr_chan_q),
        .corr_set_q(corr_set_q), .corr_level_q(corr_level_q), .raw_level_word_q(raw_level_word_q));
    // Strobe tallies, so multi-channel pulses are all seen
    always @(posedge clk) begin
        n_corr <= n_corr + (corr_stb_q === 1'b1);
        n_wr <= n_wr + (ctrl_wr_stb_q === 1'b1);
        n_rd <= n_rd + (ctrl_rd_stb_q === 1'b1);
    end
    // Command word from its fields
    function automatic logic [31:0] mk(logic r, logic [3:0] ch, logic [1:0] t, logic [2:0] s, logic [2:0] l,
                                       logic [15:0] d);
        return {3'b000, r, ch, t, s, l, d};
    endfunction
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        checked++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            failures++;
        end
    endtask
    // Send a command and count the strobes it raised
    task automatic send(logic [31:0] c, int ec, int ew, int er);
        int c0, w0, r0;
        c0 = n_corr;
        w0 = n_wr;
        r0 = n_rd;
        host_u.xfer(1'b1, OFF_CMD, c, rd, err);
        repeat (10) @(posedge clk);
        check("corr strobes", ec, n_corr - c0);
        check("ctrl write strobes", ew, n_wr - w0);
        check("ctrl read strobes", er, n_rd - r0);
        $display("test send %h done", c);
    endtask
    // Readback: command, poll valid, fetch the word
    task automatic readback(logic [31:0] c, logic [31:0] exp);
        int n;
        host_u.xfer(1'b1, OFF_CMD, c, rd, err);
        n = 0;
        do begin
            host_u.xfer(1'b0, OFF_STATUS, 32'h0, rd, err);
            n++;
        end while (rd[ST_VALID_BIT] !== 1'b1 && n < 20);
        if (n >= 20) begin
            $display("BAD readback valid expected 1 seen 0");
            failures++;
        end
        host_u.xfer(1'b0, OFF_RDATA, 32'h0, rd, err);
        check("readback word", exp, rd);
        $display("test readback %h done", c);
    endtask
    task automatic give_verdict();
        failures += host_u.lost;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        give_verdict();
    end
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        host_u.xfer(1'b0, OFF_CMD, 32'h0, rd, err);
        check("cmd after reset", 32'h0000_0000, rd);
        send(mk(1'b0, 4'h9, TGT_GAIN, 3'h5, 3'h2, 16'hABCD), 0, 0, 0);
        readback(mk(1'b1, 4'h8, TGT_GAIN, 3'h5, 3'h2, 16'h0), 32'h0001_ABCC);
        readback(mk(1'b1, 4'h1, TGT_GAIN, 3'h5, 3'h2, 16'h0), 32'h0001_ABCC);
        send(mk(1'b0, 4'h2, TGT_OFFSET, 3'h5, 3'h2, 16'h1235), 0, 0, 0);
        readback(mk(1'b1, 4'h2, TGT_OFFSET, 3'h5, 3'h2, 16'h0), 32'h0001_1235);
        send(mk(1'b0, 4'hF, TGT_INPUT, 3'h2, 3'h7, 16'h8001), 4, 0, 0);
        check("corr set level word", {3'h2, 3'h7, 16'h8001}, {corr_set_q, corr_level_q, raw_level_word_q});
        readback(mk(1'b1, 4'h4, TGT_INPUT, 3'h2, 3'h7, 16'h0), 32'h0001_8001);
        send(mk(1'b0, 4'h4, TGT_CTRL, 3'h7, 3'h1, 16'h5A5A), 0, 1, 0);
        check("ctrl chan and word", {2'h2, 22'h395A5A}, {ctrl_chan_q, ctrl_word_q});
        send(mk(1'b0, 4'h1, TGT_INPUT, 3'h0, 3'h0, 16'h7FFF), 1, 0, 0);
        send(mk(1'b1, 4'h1, TGT_CTRL, 3'h0, 3'h0, 16'h0), 0, 0, 1);
        host_u.xfer(1'b0, 12'h010, 32'h0, rd, err);
        check("unmapped error", 32'h1, {31'h0, err});
        give_verdict();
    end
endmodule
`default_nettype wire
